/* verilog/csi_pkg.sv */
/*
  Shared constants, enumerations and carriers of the core-side
  stack, register file and interrupt logic.
  Assumes a single core clock and an instruction decoder that issues
  one decoded operation per cycle.
*/
`default_nettype none
package csi_pkg;
  // status flag positions and reset value
  localparam logic [2:0] CARRY_BIT = 3'h0;
  localparam logic [2:0] GIE_BIT = 3'h7;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
  // io addresses of the stack pointer bytes
  localparam logic [5:0] IO_SP_LOW = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  // data space of the register file and pointer pairs
  localparam logic [15:0] REG_FILE_TOP = 16'h001f;
  localparam logic [4:0] PTR_BASE = 5'h1a;
  localparam logic [4:0] PROD_LOW = 5'h00;
  localparam logic [4:0] PROD_HIGH = 5'h01;
  // vectors and stack steps
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0001;
  // sequencer counts: entry and return both span four cycles
  localparam logic [1:0] SEQ_LAST = 2'h3;
  localparam logic [1:0] POP_HIGH_CYC = 2'h2;
  localparam logic [1:0] PUSH_BYTES = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_MOV, OP_MUL,
    OP_MOVW, OP_ADIW, OP_LD, OP_ST, OP_PUSH, OP_POP, OP_CALL,
    OP_RET, OP_INTERRUPT_EXIT_INSTR, OP_IN, OP_OUT, OP_SEI, OP_CLI
  } csi_op_e;

  typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP} csi_am_e;

  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_PUSH, ST_POP} csi_state_e;

  // one decoded operation; disp doubles as io address for in/out
  typedef struct packed {
    logic valid;
    csi_op_e kind;
    csi_am_e mode;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [1:0] ptr;
    logic [5:0] disp;
    logic [7:0] imm;
    logic [15:0] next_pc;
    logic [15:0] target;
  } csi_op_s;

  // data memory request
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } csi_mem_s;
endpackage : csi_pkg
`default_nettype wire

/* verilog/csi_core.sv */
/*
  Core-side carry flag, register file, pointers, stack pointer and
  interrupt acceptance and dispatch.
  Assumes the decoder holds ops while busy_q is high, that data memory
  returns read data two cycles after the request cycle, and that
  interrupt sources run on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module csi_core
  import csi_pkg::*;
#(
  parameter int NUM_IRQ = 4,
  parameter logic [NUM_IRQ-1:0] LEVEL_MASK = '0,
  parameter logic [15:0] LAST_DATA_RAM_ADDRESS = 16'h04ff,
  parameter logic [15:0] BOOT_START = 16'h0c00,
  parameter logic [15:0] VEC_STEP = 16'h0001
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire csi_op_s op,
  input wire logic [7:0] mem_rdata,
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] irq_level,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_flag_clear,
  input wire logic vector_relocate_bit,
  input wire logic boot_reset_vector_fuse,
  input wire logic boot_lock_app_bit,
  input wire logic boot_lock_loader_bit,
  output var csi_mem_s mem_q,
  output logic pc_load_q,
  output logic [15:0] pc_target_q,
  output logic [7:0] status_flags_q,
  output logic [15:0] stack_top_q,
  output logic busy_q,
  output logic [NUM_IRQ-1:0] irq_flag_q
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] rf_q [32];
  csi_state_e st_q;
  logic [1:0] cnt_q;
  logic is_int_q;
  logic [15:0] ret_q;
  logic [15:0] vec_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [1:0] pend_v_q;
  logic [4:0] pend_rd0_q;
  logic [4:0] pend_rd1_q;
  logic ex;
  logic [7:0] rd_v;
  logic [7:0] rr_v;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_v;
  logic [15:0] eff;
  logic [15:0] ptr_new;
  logic reg_hit;
  logic [8:0] alu_res;
  logic [15:0] prod;
  logic [16:0] wsum;
  logic [7:0] io_rd;
  logic [NUM_IRQ-1:0] req;
  logic [NUM_IRQ-1:0] ack;
  logic [$clog2(NUM_IRQ+1)-1:0] win;
  logic suppress;
  logic flow_op;
  logic take;
  logic [15:0] win_vec;

  // lowest set index wins: lower vector address is higher priority
  function automatic logic [$clog2(NUM_IRQ+1)-1:0] lowest(input logic [NUM_IRQ-1:0] v);
    lowest = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = ($clog2(NUM_IRQ+1))'(i);
      end
    end
  endfunction : lowest

  ////////////////////////////////////////////////////////////////////
  // static straps pass two flops; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {boot_reset_vector_fuse, boot_lock_app_bit, boot_lock_loader_bit};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operand read and datapath; all of it settles within one sys_clk
  // cycle, which is the undivided core clock
  assign ex = op.valid && (st_q == ST_RUN);
  assign rd_v = rf_q[op.rd];
  assign rr_v = rf_q[op.rr];
  assign ptr_lo = PTR_BASE + {2'b00, op.ptr, 1'b0};
  assign ptr_v = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
  assign prod = rd_v * rr_v;
  assign wsum = {1'b0, rf_q[{op.rd[4:1], 1'b1}], rf_q[{op.rd[4:1], 1'b0}]} + {9'h000, op.imm};
  assign io_rd = (op.disp == IO_SP_LOW) ? stack_top_q[7:0] :
                 (op.disp == IO_SP_HIGH) ? stack_top_q[15:8] : 8'h00;

  // effective address and pointer update per addressing mode
  always_comb begin
    eff = ptr_v;
    ptr_new = ptr_v;
    case (op.mode)
      AM_DISP: eff = ptr_v + {10'h000, op.disp};
      AM_POSTINC: ptr_new = ptr_v + STACK_STEP;
      AM_PREDEC: begin
        eff = ptr_v - STACK_STEP;
        ptr_new = ptr_v - STACK_STEP;
      end
      default: eff = ptr_v;
    endcase
  end

  assign reg_hit = (eff <= REG_FILE_TOP);

  // 8-bit alu with carry out in bit 8
  always_comb begin
    alu_res = 9'h000;
    case (op.kind)
      OP_ADD: alu_res = {1'b0, rd_v} + {1'b0, rr_v};
      OP_ADC: alu_res = {1'b0, rd_v} + {1'b0, rr_v} + {8'h00, status_flags_q[CARRY_BIT]};
      OP_SUB: alu_res = {1'b0, rd_v} - {1'b0, rr_v};
      OP_AND: alu_res = {1'b0, rd_v & rr_v};
      OP_OR: alu_res = {1'b0, rd_v | rr_v};
      default: alu_res = 9'h000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // register file writes; a returning load lands last so it wins
  always_ff @(posedge sys_clk) begin
    if (ex) begin
      case (op.kind)
        OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR: rf_q[op.rd] <= alu_res[7:0];
        OP_MOV: rf_q[op.rd] <= rr_v;
        OP_MUL: begin
          rf_q[PROD_LOW] <= prod[7:0];
          rf_q[PROD_HIGH] <= prod[15:8];
        end
        OP_MOVW: begin
          rf_q[{op.rd[4:1], 1'b0}] <= rf_q[{op.rr[4:1], 1'b0}];
          rf_q[{op.rd[4:1], 1'b1}] <= rf_q[{op.rr[4:1], 1'b1}];
        end
        OP_ADIW: begin
          rf_q[{op.rd[4:1], 1'b0}] <= wsum[7:0];
          rf_q[{op.rd[4:1], 1'b1}] <= wsum[15:8];
        end
        OP_LD: if (reg_hit) rf_q[op.rd] <= rf_q[eff[4:0]];
        OP_ST: if (reg_hit) rf_q[eff[4:0]] <= rd_v;
        OP_IN: rf_q[op.rd] <= io_rd;
        default: ;
      endcase
      // pointer write-back after the data move
      if ((op.kind == OP_LD || op.kind == OP_ST) && op.mode inside {AM_POSTINC, AM_PREDEC}) begin
        rf_q[ptr_lo] <= ptr_new[7:0];
        rf_q[ptr_lo + 5'h01] <= ptr_new[15:8];
      end
    end
    if (pend_v_q[1]) begin
      rf_q[pend_rd1_q] <= mem_rdata;
    end
  end

  // load tracking for the two-cycle memory read latency
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_v_q <= 2'b00;
      pend_rd0_q <= 5'h00;
      pend_rd1_q <= 5'h00;
    end else begin
      pend_v_q <= {pend_v_q[0], ex && ((op.kind == OP_LD && !reg_hit) || op.kind == OP_POP)};
      pend_rd0_q <= op.rd;
      pend_rd1_q <= pend_rd0_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stack pointer: grows downward, one byte in each of the first two sequencer cycles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stack_top_q <= LAST_DATA_RAM_ADDRESS;
    end else if (st_q == ST_PUSH && cnt_q < PUSH_BYTES) begin
      stack_top_q <= stack_top_q - STACK_STEP;
    end else if (st_q == ST_POP && cnt_q < PUSH_BYTES) begin
      stack_top_q <= stack_top_q + STACK_STEP;
    end else if (ex) begin
      case (op.kind)
        OP_PUSH: stack_top_q <= stack_top_q - STACK_STEP;
        OP_POP: stack_top_q <= stack_top_q + STACK_STEP;
        OP_OUT: begin
          if (op.disp == IO_SP_LOW) stack_top_q[7:0] <= rd_v;
          else if (op.disp == IO_SP_HIGH) stack_top_q[15:8] <= rd_v;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data memory requests; return address goes low byte first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_q <= '0;
    end else begin
      mem_q <= '0;
      if (st_q == ST_PUSH && cnt_q < PUSH_BYTES) begin
        mem_q.we <= 1'b1;
        mem_q.addr <= stack_top_q;
        mem_q.wdata <= (cnt_q == 2'h0) ? ret_q[7:0] : ret_q[15:8];
      end else if (st_q == ST_POP && cnt_q < PUSH_BYTES) begin
        mem_q.re <= 1'b1;
        mem_q.addr <= stack_top_q + STACK_STEP;
      end else if (ex) begin
        if (op.kind == OP_LD && !reg_hit) begin
          mem_q.re <= 1'b1;
          mem_q.addr <= eff;
        end else if (op.kind == OP_ST && !reg_hit) begin
          mem_q.we <= 1'b1;
          mem_q.addr <= eff;
          mem_q.wdata <= rd_v;
        end else if (op.kind == OP_PUSH) begin
          mem_q.we <= 1'b1;
          mem_q.addr <= stack_top_q;
          mem_q.wdata <= rd_v;
        end else if (op.kind == OP_POP) begin
          mem_q.re <= 1'b1;
          mem_q.addr <= stack_top_q + STACK_STEP;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt requests: flags for event sources, live level otherwise
  assign req = ((irq_flag_q & ~LEVEL_MASK) | (irq_level & LEVEL_MASK)) & irq_enable;
  assign win = lowest(req);
  // interpretation: a lock bit blocks interrupts while executing in its own section
  assign suppress = (sync2_q[1] && op.next_pc < BOOT_START) ||
                    (sync2_q[0] && op.next_pc >= BOOT_START);
  assign flow_op = op.kind inside {OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTR, OP_CLI};
  // taken only after an executed op, so one op always follows a return
  // or an enable before any pending request is served
  assign take = ex && status_flags_q[GIE_BIT] && (|req) && !suppress && !flow_op;
  assign win_vec = (vector_relocate_bit ? BOOT_START : RESET_VECTOR) +
                   16'(VEC_STEP * (32'(win) + 32'd1));
  assign ack = take ? (NUM_IRQ'(1) << win) & ~LEVEL_MASK : '0;

  // sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_flag_q <= '0;
    end else begin
      irq_flag_q <= (irq_flag_q & ~irq_flag_clear & ~ack) | (irq_event & ~LEVEL_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status: carry and global enable; nothing is stacked on entry
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_flags_q <= STATUS_FLAGS_REGISTER_RESET;
    end else begin
      if (take) begin
        status_flags_q[GIE_BIT] <= 1'b0;
      end else if (st_q == ST_POP && cnt_q == SEQ_LAST && is_int_q) begin
        status_flags_q[GIE_BIT] <= 1'b1;
      end else if (ex && op.kind == OP_SEI) begin
        status_flags_q[GIE_BIT] <= 1'b1;
      end else if (ex && op.kind == OP_CLI) begin
        status_flags_q[GIE_BIT] <= 1'b0;
      end
      if (ex) begin
        case (op.kind)
          OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR: status_flags_q[CARRY_BIT] <= alu_res[8];
          OP_MUL: status_flags_q[CARRY_BIT] <= prod[15];
          OP_ADIW: status_flags_q[CARRY_BIT] <= wsum[16];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer: reset vector, call/entry push, return pop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= ST_BOOT;
      cnt_q <= 2'h0;
      is_int_q <= 1'b0;
      ret_q <= 16'h0000;
      vec_q <= 16'h0000;
      busy_q <= 1'b1;
      pc_load_q <= 1'b0;
      pc_target_q <= RESET_VECTOR;
    end else begin
      pc_load_q <= 1'b0;
      cnt_q <= cnt_q + 2'h1;
      case (st_q)
        ST_BOOT: begin
          // waits for the strap synchroniser before choosing
          if (cnt_q == SEQ_LAST) begin
            st_q <= ST_RUN;
            busy_q <= 1'b0;
            pc_load_q <= 1'b1;
            pc_target_q <= sync2_q[2] ? BOOT_START : RESET_VECTOR;
          end
        end
        ST_RUN: begin
          cnt_q <= 2'h0;
          if (take) begin
            st_q <= ST_PUSH;
            busy_q <= 1'b1;
            is_int_q <= 1'b1;
            ret_q <= op.next_pc;
            vec_q <= win_vec;
          end else if (ex && op.kind == OP_CALL) begin
            st_q <= ST_PUSH;
            busy_q <= 1'b1;
            is_int_q <= 1'b0;
            ret_q <= op.next_pc;
            vec_q <= op.target;
          end else if (ex && (op.kind == OP_RET || op.kind == OP_INTERRUPT_EXIT_INSTR)) begin
            st_q <= ST_POP;
            busy_q <= 1'b1;
            is_int_q <= (op.kind == OP_INTERRUPT_EXIT_INSTR);
          end
        end
        ST_PUSH: begin
          if (cnt_q == SEQ_LAST) begin
            st_q <= ST_RUN;
            busy_q <= 1'b0;
            pc_load_q <= 1'b1;
            pc_target_q <= vec_q;
          end
        end
        default: begin
          if (cnt_q == POP_HIGH_CYC) begin
            ret_q[15:8] <= mem_rdata;
          end
          if (cnt_q == SEQ_LAST) begin
            st_q <= ST_RUN;
            busy_q <= 1'b0;
            pc_load_q <= 1'b1;
            pc_target_q <= {ret_q[15:8], mem_rdata};
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_carry;
    @(posedge sys_clk) disable iff (reset)
    (ex && op.kind == OP_ADD) |=> status_flags_q[CARRY_BIT] == $past(alu_res[8]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not taken from add");

  property p_push_sp;
    @(posedge sys_clk) disable iff (reset)
    (ex && op.kind == OP_PUSH) |=> stack_top_q == $past(stack_top_q) - 16'h0001;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push did not lower sp by one");

  property p_call_sp;
    @(posedge sys_clk) disable iff (reset)
    (ex && op.kind == OP_CALL) |-> ##3 stack_top_q == $past(stack_top_q, 3) - 16'h0002;
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("call did not lower sp by two");

  property p_entry_gie;
    @(posedge sys_clk) disable iff (reset)
    take |=> !status_flags_q[GIE_BIT] && busy_q;
  endproperty
  a_entry_gie: assert property (p_entry_gie) else $error("entry kept global enable");

  property p_entry_time;
    @(posedge sys_clk) disable iff (reset)
    take |-> ##1 (!pc_load_q)[*4] ##1 (pc_load_q && pc_target_q == $past(win_vec, 5));
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("vector not loaded at cycle five");

  property p_interrupt_exit_instr;
    @(posedge sys_clk) disable iff (reset)
    (ex && op.kind == OP_INTERRUPT_EXIT_INSTR) |-> ##5 (pc_load_q && status_flags_q[GIE_BIT]
      && stack_top_q == $past(stack_top_q, 5) + 16'h0002);
  endproperty
  a_interrupt_exit_instr: assert property (p_interrupt_exit_instr) else $error("return did not restore pc and enable");

  property p_cli;
    @(posedge sys_clk) disable iff (reset)
    (ex && op.kind == OP_CLI) |-> !take ##1 (!take)[*2];
  endproperty
  a_cli: assert property (p_cli) else $error("interrupt taken after disable");

  property p_gate;
    @(posedge sys_clk) disable iff (reset)
    (st_q == ST_PUSH && cnt_q == 2'h0 && is_int_q) |-> $past(status_flags_q[GIE_BIT])
      && $past(req) != '0;
  endproperty
  a_gate: assert property (p_gate) else $error("entry without enables");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (reset)
    (irq_flag_q[0] && !irq_flag_clear[0] && !ack[0]) |=> irq_flag_q[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("pending flag lost");

endmodule : csi_core
`default_nettype wire

/* testbench/csi_mem_model.sv */
/*
  Data memory model on the far side of the core: stores pushes and
  answers a read in the cycle after the request shows on mem_q.
  Assumes one sys_clk domain and byte addresses below 0x0800.
*/
`timescale 1ns/1ns
`default_nettype none
module csi_mem_model
  import csi_pkg::*;
(
  input wire logic sys_clk,
  input wire csi_mem_s mem_q,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:2047];

  ////////////////////////////////////////////////////////////////////////
  // one register stage, so the core samples the byte two edges after it
  // raised the request; an idle bus shows inverted data, having no pull
  initial mem_rdata = 8'h5a;
  always @(posedge sys_clk) begin
    if (mem_q.we) ram[mem_q.addr[10:0]] <= mem_q.wdata;
    mem_rdata <= mem_q.re ? ram[mem_q.addr[10:0]] : ~mem_rdata;
  end
endmodule : csi_mem_model
`default_nettype wire

/* testbench/cpu_stack_interrupt_core_bench.sv */
/*
  Self-checking bench of the core: carry, io stack pointer, push/pop,
  call/return, interrupt dispatch, boot locks and level requests.
  Assumes the data memory model and a 50 MHz sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module cpu_stack_interrupt_core_bench
  import csi_pkg::*;
;
  localparam logic [15:0] LAST = 16'h04ff;
  localparam logic [15:0] BOOT = 16'h0c00;
  localparam logic [15:0] STEP = 16'h0002;
  localparam logic [15:0] NPC = 16'h0123;
  logic sys_clk, reset, pc_load_q, busy_q, reloc, lock_app, lock_ldr;
  csi_op_s op;
  csi_mem_s mem_q;
  logic [7:0] mem_rdata, status_flags_q;
  logic [15:0] pc_target_q, stack_top_q;
  logic [3:0] irq_event, irq_level, irq_enable, irq_flag_clear, irq_flag_q;
  int fails = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////////
  // source 3 is level-type so the level path is exercised
  csi_core #(.NUM_IRQ(4), .LEVEL_MASK(4'h8), .LAST_DATA_RAM_ADDRESS(LAST),
    .BOOT_START(BOOT), .VEC_STEP(STEP)) DUT (
    .sys_clk(sys_clk), .reset(reset), .op(op), .mem_rdata(mem_rdata),
    .irq_event(irq_event), .irq_level(irq_level), .irq_enable(irq_enable),
    .irq_flag_clear(irq_flag_clear), .vector_relocate_bit(reloc),
    .boot_reset_vector_fuse(1'b0), .boot_lock_app_bit(lock_app),
    .boot_lock_loader_bit(lock_ldr), .mem_q(mem_q), .pc_load_q(pc_load_q),
    .pc_target_q(pc_target_q), .status_flags_q(status_flags_q),
    .stack_top_q(stack_top_q), .busy_q(busy_q), .irq_flag_q(irq_flag_q));
  csi_mem_model memory (.sys_clk(sys_clk), .mem_q(mem_q), .mem_rdata(mem_rdata));

  // 20 ns core clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // one op, held until taken while busy is low; returns just after taking
  task automatic issue(csi_op_e k, logic [4:0] r, logic [5:0] io, logic [15:0] tgt);
    csi_op_s o;
    o = '0;
    o.valid = 1'b1;
    o.kind = k;
    o.mode = AM_PLAIN;
    o.rd = r;
    o.rr = r;
    o.disp = io;
    o.next_pc = NPC;
    o.target = tgt;
    @(posedge sys_clk);
    while (busy_q !== 1'b0) @(posedge sys_clk);
    op <= o;
    @(posedge sys_clk);
    op <= '0;
    #1;
  endtask : issue

  // bounded wait for the fetch reload, then its target
  task automatic wait_pc(logic [15:0] t);
    int n;
    n = 0;
    while (pc_load_q !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(pc_load_q, 1'b1)
    `CHK(pc_target_q, t)
  endtask : wait_pc

  task automatic pulse_event(logic [3:0] v);
    @(posedge sys_clk) irq_event <= v;
    @(posedge sys_clk) irq_event <= 4'h0;
  endtask : pulse_event

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_pc(RESET_VECTOR);
    `CHK(stack_top_q, LAST)
    `CHK(status_flags_q, STATUS_FLAGS_REGISTER_RESET)
  endtask : t_reset

  // 0xff doubled carries out, 0x04 doubled does not
  task automatic t_carry();
    issue(OP_IN, 5'h00, IO_SP_LOW, 16'h0000);
    issue(OP_IN, 5'h01, IO_SP_HIGH, 16'h0000);
    issue(OP_ADD, 5'h00, 6'h00, 16'h0000);
    `CHK(status_flags_q[CARRY_BIT], 1'b1)
    issue(OP_ADD, 5'h01, 6'h00, 16'h0000);
    `CHK(status_flags_q[CARRY_BIT], 1'b0)
    issue(OP_OUT, 5'h00, IO_SP_LOW, 16'h0000);
    `CHK(stack_top_q, 16'h04fe)
  endtask : t_carry

  task automatic t_push_pop();
    issue(OP_PUSH, 5'h01, 6'h00, 16'h0000);
    `CHK(stack_top_q, 16'h04fd)
    issue(OP_POP, 5'h02, 6'h00, 16'h0000);
    `CHK(stack_top_q, 16'h04fe)
    repeat (3) @(posedge sys_clk);
    issue(OP_OUT, 5'h02, IO_SP_LOW, 16'h0000);
    `CHK(stack_top_q, 16'h0408)
  endtask : t_push_pop

  task automatic t_call_ret();
    issue(OP_CALL, 5'h00, 6'h00, 16'h0200);
    `CHK(busy_q, 1'b1)
    wait_pc(16'h0200);
    `CHK(stack_top_q, 16'h0406)
    issue(OP_RET, 5'h00, 6'h00, 16'h0000);
    wait_pc(NPC);
    `CHK(stack_top_q, 16'h0408)
  endtask : t_call_ret

  // two flags pend while masked, then are served lowest index first
  task automatic t_irq();
    @(posedge sys_clk) irq_enable <= 4'b0110;
    pulse_event(4'b0110);
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    `CHK(irq_flag_q, 4'b0110)
    issue(OP_SEI, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(status_flags_q[GIE_BIT], 1'b0)
    `CHK(irq_flag_q, 4'b0100)
    wait_pc(STEP * 2);
    `CHK(stack_top_q, 16'h0406)
    @(posedge sys_clk) reloc <= 1'b1;
    issue(OP_INTERRUPT_EXIT_INSTR, 5'h00, 6'h00, 16'h0000);
    wait_pc(NPC);
    `CHK(status_flags_q[GIE_BIT], 1'b1)
    `CHK(stack_top_q, 16'h0408)
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    wait_pc(BOOT + STEP * 3);
    issue(OP_INTERRUPT_EXIT_INSTR, 5'h00, 6'h00, 16'h0000);
    wait_pc(NPC);
    @(posedge sys_clk) reloc <= 1'b0;
  endtask : t_irq

  // a request that becomes eligible at the masking op is not served
  task automatic t_cli();
    pulse_event(4'b0001);
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    @(posedge sys_clk) irq_enable <= 4'b0111;
    issue(OP_CLI, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    `CHK(status_flags_q[GIE_BIT], 1'b0)
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    @(posedge sys_clk) irq_flag_clear <= 4'b0001;
    @(posedge sys_clk) irq_flag_clear <= 4'h0;
    @(posedge sys_clk);
    #1;
    `CHK(irq_flag_q, 4'h0)
  endtask : t_cli

  // app lock hides requests below the boot start, loader lock does not;
  // the straps need two extra edges to cross their synchroniser
  task automatic t_lock();
    @(posedge sys_clk) lock_app <= 1'b1;
    pulse_event(4'b0010);
    issue(OP_SEI, 5'h00, 6'h00, 16'h0000);
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    `CHK(irq_flag_q, 4'b0010)
    @(posedge sys_clk) begin
      lock_app <= 1'b0;
      lock_ldr <= 1'b1;
    end
    repeat (2) @(posedge sys_clk);
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(irq_flag_q, 4'h0)
    wait_pc(STEP * 2);
    issue(OP_INTERRUPT_EXIT_INSTR, 5'h00, 6'h00, 16'h0000);
    wait_pc(NPC);
    @(posedge sys_clk) lock_ldr <= 1'b0;
  endtask : t_lock

  // a level request gone before enabling is never served; a live one is
  task automatic t_level();
    @(posedge sys_clk) irq_level <= 4'h8;
    @(posedge sys_clk) irq_level <= 4'h0;
    @(posedge sys_clk) irq_enable <= 4'hf;
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b0)
    `CHK(irq_flag_q, 4'h0)
    @(posedge sys_clk) irq_level <= 4'h8;
    issue(OP_NOP, 5'h00, 6'h00, 16'h0000);
    `CHK(busy_q, 1'b1)
    wait_pc(STEP * 4);
    @(posedge sys_clk) irq_level <= 4'h0;
    issue(OP_INTERRUPT_EXIT_INSTR, 5'h00, 6'h00, 16'h0000);
    wait_pc(NPC);
  endtask : t_level

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    op = '0;
    irq_event = 4'h0;
    irq_enable = 4'h0;
    irq_flag_clear = 4'h0;
    reloc = 1'b0;
    lock_app = 1'b0;
    lock_ldr = 1'b0;
    irq_level = 4'h0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_carry();
    t_push_pop();
    t_call_ret();
    t_irq();
    t_cli();
    t_lock();
    t_level();
    report_and_stop();
  end

  // watchdog; the whole run needs about 125 cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
endmodule : cpu_stack_interrupt_core_bench
`default_nettype wire
